// ==== rtl/wsw_top.sv ====
// Watchdog timer and power-down/wake-up controller with a Wishbone register port.
`timescale 1ns/1ps
module wsw_top
(
    input logic clock_i,
    input logic rst_i,
    input logic [wsw_pkg::ADR_W-1:0] wb_adr_i,
    input logic [wsw_pkg::DAT_W-1:0] wb_dat_i,
    input logic [3:0] wb_sel_i,
    input logic wb_we_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    output logic [wsw_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input logic por_i,
    input logic master_clear_pin_n_i,
    input logic wdt_osc_i,
    input logic clear_watchdog_instr_i,
    input logic sleep_instr_i,
    input logic [wsw_pkg::PC_W-1:0] pc_i,
    input logic [wsw_pkg::IRQ_W-1:0] irq_flags_i,
    input logic [wsw_pkg::IRQ_W-1:0] irq_enables_i,
    input logic global_irq_enable_i,
    input logic timer_count_i,
    input logic [wsw_pkg::IO_W-1:0] io_out_i,
    input logic [wsw_pkg::IO_W-1:0] io_oe_i,
    output logic [wsw_pkg::IO_W-1:0] io_out_o,
    output logic [wsw_pkg::IO_W-1:0] io_oe_o,
    output logic device_reset_o,
    output logic wdt_reset_o,
    output logic osc_drive_o,
    output logic core_run_o,
    output logic wake_o,
    output logic prefetch_o,
    output logic [wsw_pkg::PC_W-1:0] prefetch_addr_o,
    output logic vector_o,
    output logic [wsw_pkg::PC_W-1:0] vector_addr_o,
    output logic timer_tick_o,
    output logic timeout_status_flag_o,
    output logic powerdown_status_flag_o
);

    wsw_scaler_if sif();

    wsw_pkg::wsw_state_type state_r;
    wsw_pkg::wsw_state_type state_nxt;
    logic [7:0] option_r;
    logic [7:0] config_r;
    logic timeout_status_flag_r;
    logic powerdown_status_flag_r;
    logic wake_wdt_r;
    logic wake_irq_r;
    logic rst_wdt_r;
    logic [wsw_pkg::WDT_W-1:0] watchdog_counter_r;
    logic wdt_wrap_r;
    logic [wsw_pkg::OSC_CNT_W-1:0] start_cnt_r;
    logic osc_s1_r;
    logic osc_s2_r;
    logic osc_s3_r;
    logic osc_lvl_r;
    logic osc_edge;
    logic master_clear_pin_s1_r;
    logic master_clear_pin_s2_r;
    logic master_clear_pin_s3_r;
    logic master_clear_pin_low_r;
    logic wdt_enabled;
    logic scaler_to_wdt;
    logic wdt_expire;
    logic irq_pending;
    logic sleep_go;
    logic sleep_nop;
    logic wdt_clear;
    logic wdt_run_reset;
    logic wb_req;
    logic wb_wr;

    // ======
    // Decode of the control bits
    assign wdt_enabled = config_r[wsw_pkg::CFG_WDT_EN];
    assign scaler_to_wdt = option_r[wsw_pkg::OPT_ASSIGN];
    assign irq_pending = wsw_pkg::wsw_irq_pending(irq_flags_i, irq_enables_i);
    // A sleep issued with an enabled interrupt already pending is swallowed.
    assign sleep_go = sleep_instr_i && (state_r == wsw_pkg::WSW_RUN) && !irq_pending;
    assign sleep_nop = sleep_instr_i && (state_r == wsw_pkg::WSW_RUN) && irq_pending;
    assign wdt_clear = (clear_watchdog_instr_i && state_r == wsw_pkg::WSW_RUN) || sleep_go;
    assign wdt_expire = wdt_enabled && (scaler_to_wdt ? sif.tick : wdt_wrap_r);
    assign wdt_run_reset = wdt_expire && (state_r != wsw_pkg::WSW_SLEEP);

    // ======
    // Pin synchronisers: a change counts once the second and third stage agree
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
            osc_lvl_r <= 1'b0;
        end
        else
        begin
            osc_s1_r <= wdt_osc_i;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
            if (osc_s2_r == osc_s3_r)
            begin
                osc_lvl_r <= osc_s3_r;
            end
        end
    end

    assign osc_edge = (osc_s2_r == osc_s3_r) && osc_s3_r && !osc_lvl_r;

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            master_clear_pin_s1_r <= 1'b1;
            master_clear_pin_s2_r <= 1'b1;
            master_clear_pin_s3_r <= 1'b1;
            master_clear_pin_low_r <= 1'b0;
        end
        else
        begin
            master_clear_pin_s1_r <= master_clear_pin_n_i;
            master_clear_pin_s2_r <= master_clear_pin_s1_r;
            master_clear_pin_s3_r <= master_clear_pin_s2_r;
            if (master_clear_pin_s2_r == master_clear_pin_s3_r)
            begin
                master_clear_pin_low_r <= !master_clear_pin_s3_r;
            end
        end
    end

    // ======
    // Watchdog counter, stepped only by its own oscillator so a stopped core clock
    // leaves it running.
    always_ff @(posedge clock_i)
    begin
        if (rst_i || por_i || master_clear_pin_low_r || wdt_clear || wdt_expire || !wdt_enabled)
        begin
            watchdog_counter_r <= '0;
            wdt_wrap_r <= 1'b0;
        end
        else
        begin
            wdt_wrap_r <= osc_edge && (watchdog_counter_r == '1);
            if (osc_edge)
            begin
                watchdog_counter_r <= watchdog_counter_r + 1'b1;
            end
        end
    end

    // ======
    // Shared scaler: watchdog postscaler or timer prescaler
    assign sif.to_wdt = scaler_to_wdt;
    assign sif.ratio = option_r[wsw_pkg::OPT_RATIO_LO +: 3];
    assign sif.count = scaler_to_wdt ? (wdt_wrap_r && wdt_enabled) : timer_count_i;
    // The assignment bit itself is never touched by a clear.
    assign sif.clear = rst_i || por_i || master_clear_pin_low_r || (scaler_to_wdt && (wdt_clear || wdt_expire));

    wsw_scaler wsw_scaler_inst
    (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .sif(sif)
    );

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            timer_tick_o <= 1'b0;
        end
        else
        begin
            timer_tick_o <= !scaler_to_wdt && sif.tick;
        end
    end

    // ======
    // Power state sequencing
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            wsw_pkg::WSW_RUN:
            begin
                if (sleep_go)
                begin
                    state_nxt = wsw_pkg::WSW_SLEEP;
                end
            end
            wsw_pkg::WSW_SLEEP:
            begin
                if (wdt_expire || irq_pending)
                begin
                    state_nxt = wsw_pkg::WSW_RESTART;
                end
            end
            wsw_pkg::WSW_RESTART:
            begin
                if (start_cnt_r == wsw_pkg::OSC_CNT_W'(wsw_pkg::OSC_START_CYC - 1))
                begin
                    state_nxt = wsw_pkg::WSW_RUN;
                end
            end
            default:
            begin
                state_nxt = wsw_pkg::WSW_RUN;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i || por_i || master_clear_pin_low_r)
        begin
            state_r <= wsw_pkg::WSW_RUN;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i || state_r != wsw_pkg::WSW_RESTART)
        begin
            start_cnt_r <= '0;
        end
        else
        begin
            start_cnt_r <= start_cnt_r + 1'b1;
        end
    end

    // ======
    // Oscillator driver and core run enable; the core waits for the oscillator to settle.
    always_ff @(posedge clock_i)
    begin
        if (rst_i || por_i || master_clear_pin_low_r)
        begin
            osc_drive_o <= 1'b1;
            core_run_o <= 1'b1;
        end
        else if (sleep_go)
        begin
            osc_drive_o <= 1'b0;
            core_run_o <= 1'b0;
        end
        else if (state_nxt == wsw_pkg::WSW_RESTART)
        begin
            osc_drive_o <= 1'b1;
            core_run_o <= 1'b0;
        end
        else if (state_r == wsw_pkg::WSW_RESTART && state_nxt == wsw_pkg::WSW_RUN)
        begin
            core_run_o <= 1'b1;
        end
    end

    // ======
    // Wake pulse, vector request and wake cause
    always_ff @(posedge clock_i)
    begin
        if (rst_i || por_i || master_clear_pin_low_r)
        begin
            wake_o <= 1'b0;
            vector_o <= 1'b0;
            wake_wdt_r <= 1'b0;
            wake_irq_r <= 1'b0;
        end
        else
        begin
            wake_o <= state_r == wsw_pkg::WSW_RESTART && state_nxt == wsw_pkg::WSW_RUN;
            // The core runs the prefetched instruction before taking this vector.
            vector_o <= state_r == wsw_pkg::WSW_RESTART && state_nxt == wsw_pkg::WSW_RUN
                        && wake_irq_r && global_irq_enable_i;
            if (sleep_go)
            begin
                wake_wdt_r <= 1'b0;
                wake_irq_r <= 1'b0;
            end
            else if (state_r == wsw_pkg::WSW_SLEEP && wdt_expire)
            begin
                wake_wdt_r <= 1'b1;
            end
            else if (state_r == wsw_pkg::WSW_SLEEP && irq_pending)
            begin
                wake_irq_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            vector_addr_o <= wsw_pkg::IRQ_VECTOR;
        end
        else
        begin
            vector_addr_o <= wsw_pkg::IRQ_VECTOR;
        end
    end

    // ======
    // Prefetch of the next program address while sleep executes
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            prefetch_o <= 1'b0;
            prefetch_addr_o <= '0;
        end
        else
        begin
            prefetch_o <= sleep_go || sleep_nop;
            if (sleep_instr_i && state_r == wsw_pkg::WSW_RUN)
            begin
                prefetch_addr_o <= pc_i + 1'b1;
            end
        end
    end

    // ======
    // Resets
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            device_reset_o <= 1'b0;
            wdt_reset_o <= 1'b0;
        end
        else
        begin
            device_reset_o <= por_i || master_clear_pin_low_r || wdt_run_reset;
            wdt_reset_o <= wdt_run_reset;
        end
    end

    // ======
    // Status flags
    always_ff @(posedge clock_i)
    begin
        if (rst_i || por_i)
        begin
            timeout_status_flag_r <= 1'b1;
            powerdown_status_flag_r <= 1'b1;
            rst_wdt_r <= 1'b0;
        end
        else if (wdt_expire)
        begin
            timeout_status_flag_r <= 1'b0;
            rst_wdt_r <= state_r != wsw_pkg::WSW_SLEEP;
        end
        else if (sleep_go)
        begin
            timeout_status_flag_r <= 1'b1;
            powerdown_status_flag_r <= 1'b0;
        end
        else if (clear_watchdog_instr_i && state_r == wsw_pkg::WSW_RUN)
        begin
            timeout_status_flag_r <= 1'b1;
            powerdown_status_flag_r <= 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            timeout_status_flag_o <= 1'b1;
            powerdown_status_flag_o <= 1'b1;
        end
        else
        begin
            timeout_status_flag_o <= timeout_status_flag_r;
            powerdown_status_flag_o <= powerdown_status_flag_r;
        end
    end

    // ======
    // Pin state: follow the core while running, freeze from sleep entry to wake.
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            io_out_o <= '0;
            io_oe_o <= '0;
        end
        else if (state_r == wsw_pkg::WSW_RUN && !sleep_go)
        begin
            io_out_o <= io_out_i;
            io_oe_o <= io_oe_i;
        end
        else if (sleep_go)
        begin
            io_out_o <= io_out_i;
            io_oe_o <= io_oe_i;
        end
    end

    // ======
    // Wishbone slave: one registered ack per request, a cycle after the strobe, unmapped reads return zero.
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            option_r <= wsw_pkg::OPTION_RESET;
            config_r <= wsw_pkg::CONFIG_RESET;
        end
        else if (wb_wr && wb_adr_i == wsw_pkg::OPTION_ADDR)
        begin
            option_r <= wb_dat_i[7:0];
        end
        else if (wb_wr && wb_adr_i == wsw_pkg::CONFIG_ADDR)
        begin
            config_r <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= '0;
            if (wb_req && !wb_we_i)
            begin
                case (wb_adr_i)
                    wsw_pkg::OPTION_ADDR: wb_dat_o <= {24'h000000, option_r};
                    wsw_pkg::CONFIG_ADDR: wb_dat_o <= {24'h000000, config_r};
                    wsw_pkg::STATUS_ADDR:
                    begin
                        wb_dat_o[wsw_pkg::STA_TO] <= timeout_status_flag_r;
                        wb_dat_o[wsw_pkg::STA_PD] <= powerdown_status_flag_r;
                        wb_dat_o[wsw_pkg::STA_RST_WDT] <= rst_wdt_r;
                        wb_dat_o[wsw_pkg::STA_WAKE_IRQ] <= wake_irq_r;
                        wb_dat_o[wsw_pkg::STA_WAKE_WDT] <= wake_wdt_r;
                    end
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

endmodule

// ==== shared/wsw_pkg.sv ====
// Constants, register map and helper functions of the watchdog and power-down block.
// Functional notes
// - Watchdog counts edges of its own oscillator, unaffected by a stopped core clock.
// - Watchdog expiry while running produces a device reset flagged as watchdog reset.
// - Watchdog expiry while asleep wakes the device instead of resetting it.
// - Any watchdog expiry clears the time-out flag, on reset or wake alike.
// - Configuration enable bit at zero keeps the watchdog disabled until the bit is written back to one.
// - One scaler serves watchdog or timer; option fields pick owner and ratio.
// - Clear-watchdog and sleep both clear the count and an assigned scaler.
// - Clear-watchdog zeroes the scaler count when it is assigned to the watchdog, but keeps the scaler assignment.
// - Sleep entry clears watchdog, clears power-down flag, sets time-out flag, stops oscillator.
// - Pins keep their driven or released state throughout power-down.
// - Power-down ends on master clear, enabled watchdog expiry, or enabled interrupt.
// - Master clear in power-down resets; every other source resumes as a wake-up.
// - Power-up sets the power-down flag; sleep clears it; flags reveal the cause.
// - Only clockless peripheral interrupts can wake; their flags arrive as plain inputs.
// - During sleep the instruction at program counter plus one is prefetched.
// - Interrupt wake needs the source enable bit, whatever the global enable holds.
// - After interrupt wake run the next instruction, then vector to 0004h if enabled.
// - Sleep with an enabled interrupt already pending acts as a no-operation.
// - Interrupt during or after sleep: complete sleep effects, then wake at once.
package wsw_pkg;

    // ======
    // Bus and register map
    localparam int ADR_W = 16;
    localparam int DAT_W = 32;
    localparam logic [13:0] OPTION_INDEX = 14'h0081;
    localparam logic [13:0] CONFIG_INDEX = 14'h2007;
    localparam logic [13:0] STATUS_INDEX = 14'h0003;
    localparam logic [15:0] OPTION_ADDR = {OPTION_INDEX, 2'b00};
    localparam logic [15:0] CONFIG_ADDR = {CONFIG_INDEX, 2'b00};
    localparam logic [15:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};

    // ======
    // Field positions and reset values
    localparam int OPT_RATIO_LO = 0;
    localparam int OPT_ASSIGN = 3;
    localparam int CFG_WDT_EN = 2;
    localparam int STA_PD = 3;
    localparam int STA_TO = 4;
    localparam int STA_WAKE_WDT = 0;
    localparam int STA_WAKE_IRQ = 1;
    localparam int STA_RST_WDT = 2;
    localparam logic [7:0] OPTION_RESET = 8'hff;
    localparam logic [7:0] CONFIG_RESET = 8'hff;

    // ======
    // Widths and timing
    localparam int WDT_W = 8;
    localparam int SCL_W = 8;
    localparam int PC_W = 13;
    localparam int IRQ_W = 8;
    localparam int IO_W = 8;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
    localparam int CLK_MHZ = 20;
    localparam int OSC_START_NS = 1000;
    localparam int OSC_START_CYC = (OSC_START_NS * CLK_MHZ + 999) / 1000;
    localparam int OSC_CNT_W = 5;

    typedef enum logic [1:0] {WSW_RUN, WSW_SLEEP, WSW_RESTART} wsw_state_type;

    // Mask of low scaler bits that must all be one before the scaler emits a tick.
    function automatic logic [SCL_W-1:0] wsw_scale_mask(input logic to_wdt,
                                                        input logic [2:0] ratio);
        logic [3:0] shift;
        shift = to_wdt ? {1'b0, ratio} : {1'b0, ratio} + 4'h1;
        return SCL_W'((9'h001 << shift) - 9'h001);
    endfunction

    // Any interrupt source whose flag and own enable are both set.
    function automatic logic wsw_irq_pending(input logic [IRQ_W-1:0] flags,
                                             input logic [IRQ_W-1:0] enables);
        return |(flags & enables);
    endfunction

endpackage

// ==== shared/wsw_scaler_if.sv ====
// Signals joining the control block to the shared scaler.
`timescale 1ns/1ps
interface wsw_scaler_if;
    logic count;
    logic clear;
    logic to_wdt;
    logic [2:0] ratio;
    logic tick;

    modport ctrl (output count, output clear, output to_wdt, output ratio, input tick);
    modport scaler (input count, input clear, input to_wdt, input ratio, output tick);
endinterface

// ==== rtl/wsw_scaler.sv ====
// Scaler shared between the watchdog output and the general timer input.
`timescale 1ns/1ps
module wsw_scaler
(
    input logic clock_i,
    input logic rst_i,
    wsw_scaler_if.scaler sif
);

    logic [wsw_pkg::SCL_W-1:0] cnt_r;
    logic [wsw_pkg::SCL_W-1:0] mask;

    assign mask = wsw_pkg::wsw_scale_mask(sif.to_wdt, sif.ratio);

    // ======
    // Count
    always_ff @(posedge clock_i)
    begin
        if (rst_i || sif.clear)
        begin
            cnt_r <= '0;
        end
        else if (sif.count)
        begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // ======
    // Tick; a clear also kills a tick still in flight so no late time-out escapes.
    always_ff @(posedge clock_i)
    begin
        if (rst_i || sif.clear)
        begin
            sif.tick <= 1'b0;
        end
        else
        begin
            sif.tick <= sif.count && ((cnt_r & mask) == mask);
        end
    end

endmodule

// ==== test/wsw_core_model.sv ====
// Behavioural core issuing clear-watchdog and sleep strobes on request.
`timescale 1ns/1ps
module wsw_core_model
(
    input logic clock_i,
    input logic rst_i,
    input logic [1:0] cmd_i,
    input logic run_i,
    output logic clr_o,
    output logic sleep_o
);
    logic then_sleep_r;
    // A halted core executes nothing, so strobes are dropped, not queued, while run_i is low.
    always_ff @(posedge clock_i)
    begin
        clr_o <= 1'h0;
        sleep_o <= 1'h0;
        then_sleep_r <= 1'h0;
        if (!rst_i && run_i)
        begin
            clr_o <= cmd_i[0] && !then_sleep_r;
            sleep_o <= then_sleep_r || cmd_i == 2'h2;
            then_sleep_r <= cmd_i == 2'h3 && !then_sleep_r;
        end
    end
endmodule

// ==== test/wsw_top_asserts.sv ====
// Concurrent property checker for the watchdog and power-down block.
`timescale 1ns/1ps
module wsw_top_asserts
(
    input logic clock_i,
    input logic rst_i,
    input logic por_i,
    input logic master_clear_pin_n_i,
    input logic sleep_instr_i,
    input logic [wsw_pkg::PC_W-1:0] pc_i,
    input logic [wsw_pkg::IRQ_W-1:0] irq_flags_i,
    input logic [wsw_pkg::IRQ_W-1:0] irq_enables_i,
    input logic global_irq_enable_i,
    input logic [wsw_pkg::IO_W-1:0] io_out_o,
    input logic device_reset_o,
    input logic wdt_reset_o,
    input logic osc_drive_o,
    input logic core_run_o,
    input logic wake_o,
    input logic prefetch_o,
    input logic [wsw_pkg::PC_W-1:0] prefetch_addr_o,
    input logic vector_o,
    input logic [wsw_pkg::PC_W-1:0] vector_addr_o,
    input logic timeout_status_flag_o,
    input logic powerdown_status_flag_o
);
    // ======
    // Helper terms
    logic pend;
    logic taken;
    assign pend = |(irq_flags_i & irq_enables_i);
    // A sleep strobe only counts while the core runs and no reset is pending.
    assign taken = sleep_instr_i && core_run_o && !device_reset_o && !por_i;
    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    // ======
    // Properties
    a_sleep_halts: assert property (taken && !pend |=> !osc_drive_o && !core_run_o)
        else $error("sleep did not halt");
    a_sleep_flags: assert property (taken && !pend |-> ##2 !powerdown_status_flag_o
        && timeout_status_flag_o) else $error("sleep flags wrong");
    a_prefetch_next: assert property (taken |=> prefetch_o
        && prefetch_addr_o == $past(pc_i) + 13'h1) else $error("bad prefetch");
    a_noop_sleep: assert property (taken && pend |=> core_run_o && osc_drive_o)
        else $error("pending sleep halted");
    a_io_frozen: assert property (!osc_drive_o && !$past(osc_drive_o)
        && !device_reset_o |-> $stable(io_out_o)) else $error("pins moved asleep");
    a_wake_osc: assert property (wake_o |-> $past(osc_drive_o, 8))
        else $error("resumed without oscillator");
    a_wake_clean: assert property (wake_o |-> !device_reset_o && !wdt_reset_o)
        else $error("wake caused reset");
    a_vector_gie: assert property (vector_o |-> wake_o && global_irq_enable_i
        && vector_addr_o == 13'h0004) else $error("bad vector");
    a_wdt_reset: assert property (wdt_reset_o |-> device_reset_o
        ##[0:3] !timeout_status_flag_o) else $error("bad watchdog reset");
    a_master_clear_pin_reset: assert property (!master_clear_pin_n_i [*6] |-> device_reset_o)
        else $error("master clear ignored");
    a_por_flags: assert property (por_i |-> ##3 powerdown_status_flag_o
        && timeout_status_flag_o) else $error("power-up flags wrong");
endmodule
bind wsw_top wsw_top_asserts wsw_top_asserts_inst (.*);

// ==== test/wsw_top_bench.sv ====
// Self-checking bench for the watchdog and power-down block.
`timescale 1ns/1ps
module wsw_top_bench;
    localparam logic [15:0] OPT = wsw_pkg::OPTION_ADDR;
    localparam logic [15:0] CFG = wsw_pkg::CONFIG_ADDR;
    localparam logic [15:0] STA = wsw_pkg::STATUS_ADDR;
    logic clock_i = 1'h0;
    logic rst_i = 1'h1;
    logic [15:0] wb_adr_i = 16'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [3:0] wb_sel_i = 4'h1;
    logic wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, por_i = 1'h0, wdt_osc_i = 1'h0;
    logic master_clear_pin_n_i = 1'h1, global_irq_enable_i = 1'h0, timer_count_i = 1'h0;
    logic [12:0] pc_i = 13'h0, prefetch_addr_o, vector_addr_o;
    logic [7:0] irq_flags_i = 8'h0, irq_enables_i = 8'h0, io_out_i = 8'h0, io_out_o, io_oe_o;
    logic [1:0] cmd = 2'h0;
    logic wb_ack_o, clear_watchdog_instr_i, sleep_instr_i, device_reset_o, wdt_reset_o;
    logic osc_drive_o, core_run_o, wake_o, prefetch_o, vector_o, timer_tick_o;
    logic timeout_status_flag_o, powerdown_status_flag_o;
    wire logic [7:0] io_oe_i = ~io_out_i;
    int err_count = 0, checks_done = 0, n_wres = 0, n_wake = 0, n_vec = 0, n_tick = 0;
    always #25 clock_i = ~clock_i;
    wsw_top wsw_top_inst (.*);
    wsw_core_model wsw_core_model_inst (.clock_i(clock_i), .rst_i(rst_i), .cmd_i(cmd),
        .run_i(core_run_o), .clr_o(clear_watchdog_instr_i), .sleep_o(sleep_instr_i));
    // Pulses are counted at the edge, so a test never races a one-cycle output.
    always @(posedge clock_i)
    begin
        n_wres += wdt_reset_o === 1'h1;
        n_wake += wake_o === 1'h1;
        n_vec += vector_o === 1'h1;
        n_tick += timer_tick_o === 1'h1;
    end
    // ======
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [15:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge clock_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
            @(posedge clock_i);
        while (wb_ack_o !== 1'h1 && ++n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        if (n >= 50)
            chk(32'h0, 32'h1);
    endtask
    task automatic core(input logic [1:0] c);
        @(posedge clock_i) cmd <= c;
        @(posedge clock_i) cmd <= 2'h0;
        repeat (5) @(negedge clock_i);
    endtask
    task automatic osc_edges(input int n);
        repeat (n)
        begin
            @(posedge clock_i) wdt_osc_i <= 1'h1;
            repeat (4) @(posedge clock_i);
            wdt_osc_i <= 1'h0;
            repeat (3) @(posedge clock_i);
        end
    endtask
    task automatic close_out;
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ======
    // Scenarios
    task automatic t_regs;
        wb(OPT, 1'h0, 32'h0);
        chk(q, 32'hff);
        wb(CFG, 1'h0, 32'h0);
        chk(q, 32'hff);
        wb(STA, 1'h1, 32'h0);
        wb(STA, 1'h0, 32'h0);
        chk(q, 32'h18);
        wb(16'h0100, 1'h1, 32'h55);
        wb(16'h0100, 1'h0, 32'h0);
        chk(q, 32'h0);
        wb(OPT, 1'h1, 32'h3c);
        wb(OPT, 1'h0, 32'h0);
        chk(q, 32'h3c);
    endtask
    task automatic t_timer;
        for (int o = 0; o < 2; o++)
        begin
            wb(OPT, 1'h1, 32'(o * 8));
            n_tick = 0;
            repeat (8)
            begin
                @(posedge clock_i) timer_count_i <= 1'h1;
                @(posedge clock_i) timer_count_i <= 1'h0;
            end
            repeat (4) @(negedge clock_i);
            chk(32'(n_tick), o ? 32'h0 : 32'h4);
        end
    endtask
    task automatic t_sleep_irq(input logic g);
        @(posedge clock_i) global_irq_enable_i <= g;
        irq_enables_i <= 8'h04;
        pc_i <= 13'h0ffe;
        io_out_i <= 8'ha5;
        core(2'h3);
        chk(32'({core_run_o, osc_drive_o, powerdown_status_flag_o, timeout_status_flag_o}), 32'h1);
        @(posedge clock_i) io_out_i <= 8'h5a;
        repeat (3) @(negedge clock_i);
        chk(32'({io_oe_o, io_out_o}), 32'h5aa5);
        n_wake = 0;
        n_vec = 0;
        @(posedge clock_i) irq_flags_i <= 8'h04;
        repeat (40) @(negedge clock_i);
        chk(32'(n_wake), 32'h1);
        chk(32'(n_vec), 32'(g));
        @(posedge clock_i) irq_flags_i <= 8'h0;
        wb(STA, 1'h0, 32'h0);
        chk(q, 32'h12);
    endtask
    task automatic t_noop;
        @(posedge clock_i) irq_flags_i <= 8'h04;
        core(2'h2);
        chk(32'({core_run_o, osc_drive_o, powerdown_status_flag_o}), 32'h6);
        @(posedge clock_i) irq_flags_i <= 8'h0;
    endtask
    task automatic t_wdt(input logic sl);
        wb(OPT, 1'h1, 32'h08);
        n_wres = 0;
        n_wake = 0;
        if (sl)
        begin
            core(2'h3);
            osc_edges(270);
            chk(32'({n_wake[1:0], n_wres[1:0]}), 32'h4);
        end
        else
        begin
            core(2'h1);
            osc_edges(200);
            core(2'h1);
            osc_edges(200);
            chk(32'(n_wres), 32'h0);
            wb(OPT, 1'h0, 32'h0);
            chk(q, 32'h08);
            osc_edges(80);
            chk(32'(n_wres), 32'h1);
        end
        chk(32'(timeout_status_flag_o), 32'h0);
    endtask
    task automatic t_disabled;
        wb(OPT, 1'h1, 32'h08);
        wb(CFG, 1'h1, 32'h0);
        core(2'h1);
        n_wres = 0;
        osc_edges(300);
        chk(32'(n_wres), 32'h0);
        wb(CFG, 1'h1, 32'hff);
    endtask
    task automatic t_master_clear_pin;
        core(2'h3);
        n_wake = 0;
        @(posedge clock_i) master_clear_pin_n_i <= 1'h0;
        repeat (8) @(negedge clock_i);
        chk(32'(device_reset_o), 32'h1);
        @(posedge clock_i) master_clear_pin_n_i <= 1'h1;
        repeat (8) @(negedge clock_i);
        chk(32'({n_wake[0], core_run_o}), 32'h1);
        @(posedge clock_i) por_i <= 1'h1;
        @(posedge clock_i) por_i <= 1'h0;
        repeat (4) @(negedge clock_i);
        chk(32'({powerdown_status_flag_o, timeout_status_flag_o}), 32'h3);
    endtask
    initial
    begin
        repeat (5) @(posedge clock_i);
        rst_i <= 1'h0;
        repeat (4) @(posedge clock_i);
        t_regs;
        t_timer;
        t_sleep_irq(1'h0);
        t_sleep_irq(1'h1);
        t_noop;
        t_wdt(1'h1);
        t_wdt(1'h0);
        t_disabled;
        t_master_clear_pin;
        close_out;
    end
    initial
    begin
        #3000000;
        err_count++;
        close_out;
    end
endmodule
